// ===== core/eye_monitor_map.vh
// register map, field positions, reset values and counts of the eye monitor readout
`ifndef EYE_MONITOR_MAP_VH
`define EYE_MONITOR_MAP_VH
`define OFF_RANGE_POWER 8'h11
`define OFF_OVERRIDE 8'h22
`define OFF_SWEEP_CTRL 8'h24
`define OFF_COUNT_HIGH 8'h25
`define OFF_COUNT_LOW 8'h26
`define OFF_HORIZ_OPEN 8'h27
`define OFF_VERT_OPEN 8'h28
`define OFF_ACCUM_TIME 8'h2A
`define OFF_RANGE_OVR 8'h2C
`define OFF_LOCK_CHECK 8'h3E
`define OFF_THRESHOLDS 8'h6A
`define OFF_CHAN_SEL 8'hFF
`define BIT_RANGE_HI 7
`define BIT_RANGE_LO 6
`define BIT_POWER_DOWN 5
`define BIT_OVERRIDE 7
`define BIT_FAST_EN 7
`define BIT_START 0
`define BIT_START_ALT 1
`define BIT_RANGE_OVR 6
`define BIT_LOCK_CHECK 7
`define RST_RANGE_POWER 8'h20
`define RST_OVERRIDE 8'h00
`define RST_ACCUM_TIME 8'h0F
`define RST_RANGE_OVR 8'h40
`define RST_LOCK_CHECK 8'h80
`define RST_THRESHOLDS 8'h44
`define RST_CHAN_SEL 8'h00
`define LAST_POINT 12'hFFF
`define LAST_PAIR 13'h1001
`define CHECK_PERIOD 4096
`define SLAVE_ADDR 7'h18
`endif

// ===== core/eye_monitor_sweep_readout.v
// eye monitor lock check, fast sweep and serial management readout for one channel
// Summary of operation
// - lock check periodically measures eye openings
// - openings below thresholds restart lock acquisition
// - fast enable selects autonomous offset sweep
// - start write begins acquisition at once
// - count split into high and low bytes
// - after high byte, high register shows low
// - high byte read advances offsets, restarts counter
// - start bit clears after all data read
// - next point loads after both bytes read
// - accumulation register sets samples per point
// - high byte read takes the count so far, even before the window ends
// - cleared range override selects range field
// - range codes mean 100 to 400 mV
// - cleared power-down powers monitor unconditionally
// - capture is 64 by 64 counts
// - burst may break and resume at high register
// - power-down bit resets to one
// - opening registers return latest measurement
`timescale 1ns/100ps
`include "eye_monitor_map.vh"
module eye_monitor_sweep_readout #(
	parameter CHECK_PERIOD = `CHECK_PERIOD,
	parameter [6:0] SLAVE_ADDR = `SLAVE_ADDR
) (
	// clock, reset, enable
	input wire clock,
	input wire rst_n,
	input wire ce,
	// serial management pins
	input wire scl_in,
	input wire sda_in,
	output reg sda_out,
	output reg sda_oe,
	// comparator samples
	input wire sample_valid,
	input wire primary_bit,
	input wire offset_bit,
	// opening measurement results
	input wire opening_valid,
	input wire [7:0] horizontal_opening_in,
	input wire [7:0] vertical_opening_in,
	// clock recovery state machine
	input wire cdr_locked,
	input wire cdr_eye_use,
	input wire [1:0] cdr_range,
	output reg eye_check_req,
	output reg lock_restart,
	// eye monitor controls
	output reg eye_power_on,
	output reg [1:0] range_sel,
	output reg eye_override,
	output reg [5:0] phase_offset,
	output reg [5:0] voltage_offset,
	output reg [7:0] channel_select
);
	localparam [2:0] S_IDLE = 3'd0, S_ADDR = 3'd1, S_REG = 3'd2, S_WR = 3'd3;
	localparam [2:0] S_ACK = 3'd4, S_RD = 3'd5, S_MACK = 3'd6;

	reg [1:0] scl_sync_reg, sda_sync_reg;
	reg scl_prev_reg, sda_prev_reg;
	reg [2:0] state_reg, after_ack_reg;
	reg [3:0] bit_cnt_reg;
	reg [7:0] shift_reg, ptr_reg;
	reg nack_reg;
	reg [7:0] range_power_reg, accum_reg, range_ovr_reg, lock_check_reg, thresh_reg;
	reg fast_en_reg, sweeping_reg;
	reg [11:0] point_reg;
	reg [15:0] err_cnt_reg;
	reg [17:0] win_cnt_reg;
	reg [15:0] capture_reg, pending_reg, hold_reg;
	reg msb_taken_reg;
	reg [12:0] pairs_reg;
	reg [7:0] horiz_reg, vert_reg;
	reg [12:0] period_cnt_reg;
	reg check_pending_reg;

	wire scl = scl_sync_reg[1];
	wire sda = sda_sync_reg[1];
	wire scl_rise = scl & ~scl_prev_reg;
	wire scl_fall = ~scl & scl_prev_reg;
	wire start_cond = scl & scl_prev_reg & ~sda & sda_prev_reg;
	wire stop_cond = scl & scl_prev_reg & sda & ~sda_prev_reg;
	wire byte_done = (bit_cnt_reg == 4'd8);
	wire rx_state = (state_reg == S_ADDR) || (state_reg == S_REG) || (state_reg == S_WR);
	wire wr_fire = scl_fall & (state_reg == S_WR) & byte_done;
	wire load_first = scl_fall & (state_reg == S_ACK) & (after_ack_reg == S_RD);
	wire load_next = scl_fall & (state_reg == S_MACK) & ~nack_reg;
	wire rd_fire = load_first | load_next;
	wire rd_high = rd_fire & (ptr_reg == `OFF_COUNT_HIGH);
	wire rd_low = rd_fire & (ptr_reg == `OFF_COUNT_LOW);
	wire take_msb = rd_high & sweeping_reg & ~msb_taken_reg;
	wire take_lsb = (rd_high | rd_low) & sweeping_reg & msb_taken_reg;
	wire start_wr = wr_fire & (ptr_reg == `OFF_SWEEP_CTRL) & shift_reg[`BIT_FAST_EN]
		& (shift_reg[`BIT_START] | shift_reg[`BIT_START_ALT]);
	wire win_end = (win_cnt_reg == {accum_reg, 10'h3FF});
	wire is_error = sample_valid & (primary_bit != offset_bit);
	wire below = (horizontal_opening_in < {thresh_reg[7:4], 4'h0})
		| (vertical_opening_in < {thresh_reg[3:0], 4'h0});
	reg [7:0] rd_data;

	// readable view of the register file
	always @* begin
		rd_data = 8'h00;
		if (ptr_reg == `OFF_RANGE_POWER) begin
			rd_data = range_power_reg;
		end else if (ptr_reg == `OFF_OVERRIDE) begin
			rd_data = {eye_override, 7'h00};
		end else if (ptr_reg == `OFF_SWEEP_CTRL) begin
			rd_data = {fast_en_reg, 6'h00, sweeping_reg};
		end else if (ptr_reg == `OFF_COUNT_HIGH) begin
			rd_data = msb_taken_reg ? hold_reg[7:0] : hold_reg[15:8];
		end else if (ptr_reg == `OFF_COUNT_LOW) begin
			rd_data = hold_reg[7:0];
		end else if (ptr_reg == `OFF_HORIZ_OPEN) begin
			rd_data = horiz_reg;
		end else if (ptr_reg == `OFF_VERT_OPEN) begin
			rd_data = vert_reg;
		end else if (ptr_reg == `OFF_ACCUM_TIME) begin
			rd_data = accum_reg;
		end else if (ptr_reg == `OFF_RANGE_OVR) begin
			rd_data = range_ovr_reg;
		end else if (ptr_reg == `OFF_LOCK_CHECK) begin
			rd_data = lock_check_reg;
		end else if (ptr_reg == `OFF_THRESHOLDS) begin
			rd_data = thresh_reg;
		end else if (ptr_reg == `OFF_CHAN_SEL) begin
			rd_data = channel_select;
		end
	end

	// pin synchronisers and bus engine
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			scl_sync_reg <= 2'b11;
			sda_sync_reg <= 2'b11;
			scl_prev_reg <= 1'b1;
			sda_prev_reg <= 1'b1;
			state_reg <= S_IDLE;
			after_ack_reg <= S_IDLE;
			bit_cnt_reg <= 4'h0;
			shift_reg <= 8'h00;
			ptr_reg <= 8'h00;
			nack_reg <= 1'b1;
			sda_out <= 1'b0;
			sda_oe <= 1'b0;
		end else if (ce) begin
			scl_sync_reg <= {scl_sync_reg[0], scl_in};
			sda_sync_reg <= {sda_sync_reg[0], sda_in};
			scl_prev_reg <= scl;
			sda_prev_reg <= sda;
			sda_out <= 1'b0;
			if (start_cond) begin
				state_reg <= S_ADDR;
				bit_cnt_reg <= 4'h0;
				sda_oe <= 1'b0;
			end else if (stop_cond) begin
				state_reg <= S_IDLE;
				sda_oe <= 1'b0;
			end else if (scl_rise) begin
				if (rx_state && !byte_done) begin
					shift_reg <= {shift_reg[6:0], sda};
					bit_cnt_reg <= bit_cnt_reg + 4'h1;
				end else if (state_reg == S_MACK) begin
					nack_reg <= sda;
				end
			end else if (scl_fall) begin
				case (state_reg)
				S_ADDR, S_REG, S_WR: begin
					if (byte_done) begin
						bit_cnt_reg <= 4'h0;
						state_reg <= S_ACK;
						sda_oe <= 1'b1;
						if (state_reg == S_ADDR) begin
							if (shift_reg[7:1] != SLAVE_ADDR) begin
								state_reg <= S_IDLE;
								sda_oe <= 1'b0;
							end
							after_ack_reg <= shift_reg[0] ? S_RD : S_REG;
						end else if (state_reg == S_REG) begin
							ptr_reg <= shift_reg;
							after_ack_reg <= S_WR;
						end else begin
							after_ack_reg <= S_WR;
							if (ptr_reg != `OFF_SWEEP_CTRL) begin
								ptr_reg <= ptr_reg + 8'h01;
							end
						end
					end
				end
				S_ACK: begin
					state_reg <= after_ack_reg;
					sda_oe <= 1'b0;
					if (after_ack_reg == S_RD) begin
						shift_reg <= {rd_data[6:0], 1'b0};
						sda_oe <= ~rd_data[7];
						bit_cnt_reg <= 4'h1;
					end
				end
				S_RD: begin
					if (byte_done) begin
						sda_oe <= 1'b0;
						state_reg <= S_MACK;
					end else begin
						sda_oe <= ~shift_reg[7];
						shift_reg <= {shift_reg[6:0], 1'b0};
						bit_cnt_reg <= bit_cnt_reg + 4'h1;
					end
				end
				S_MACK: begin
					if (!nack_reg) begin
						// burst continues at the same register
						shift_reg <= {rd_data[6:0], 1'b0};
						sda_oe <= ~rd_data[7];
						bit_cnt_reg <= 4'h1;
						state_reg <= S_RD;
					end else begin
						state_reg <= S_IDLE;
					end
				end
				default: begin
					state_reg <= S_IDLE;
				end
				endcase
			end
		end
	end

	// writable registers
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			range_power_reg <= `RST_RANGE_POWER;
			eye_override <= 1'b0;
			fast_en_reg <= 1'b0;
			accum_reg <= `RST_ACCUM_TIME;
			range_ovr_reg <= `RST_RANGE_OVR;
			lock_check_reg <= `RST_LOCK_CHECK;
			thresh_reg <= `RST_THRESHOLDS;
			channel_select <= `RST_CHAN_SEL;
		end else if (ce && wr_fire) begin
			if (ptr_reg == `OFF_RANGE_POWER) begin
				range_power_reg <= shift_reg;
			end else if (ptr_reg == `OFF_OVERRIDE) begin
				eye_override <= shift_reg[`BIT_OVERRIDE];
			end else if (ptr_reg == `OFF_SWEEP_CTRL) begin
				fast_en_reg <= shift_reg[`BIT_FAST_EN];
			end else if (ptr_reg == `OFF_ACCUM_TIME) begin
				accum_reg <= shift_reg;
			end else if (ptr_reg == `OFF_RANGE_OVR) begin
				range_ovr_reg <= shift_reg;
			end else if (ptr_reg == `OFF_LOCK_CHECK) begin
				lock_check_reg <= shift_reg;
			end else if (ptr_reg == `OFF_THRESHOLDS) begin
				thresh_reg <= shift_reg;
			end else if (ptr_reg == `OFF_CHAN_SEL) begin
				channel_select <= shift_reg;
			end
		end
	end

	// fast sweep: error counting and readout pipeline
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			sweeping_reg <= 1'b0;
			point_reg <= 12'h000;
			err_cnt_reg <= 16'h0000;
			win_cnt_reg <= 18'h00000;
			capture_reg <= 16'h0000;
			pending_reg <= 16'h0000;
			hold_reg <= 16'h0000;
			msb_taken_reg <= 1'b0;
			pairs_reg <= 13'h0000;
			phase_offset <= 6'h00;
			voltage_offset <= 6'h00;
		end else if (ce) begin
			phase_offset <= point_reg[5:0];
			voltage_offset <= point_reg[11:6];
			if (start_wr && !sweeping_reg) begin
				sweeping_reg <= 1'b1;
				point_reg <= 12'h000;
				err_cnt_reg <= 16'h0000;
				win_cnt_reg <= 18'h00000;
				capture_reg <= 16'h0000;
				pending_reg <= 16'h0000;
				hold_reg <= 16'h0000;
				msb_taken_reg <= 1'b0;
				pairs_reg <= 13'h0000;
			end else if (wr_fire && ptr_reg == `OFF_SWEEP_CTRL && !shift_reg[`BIT_FAST_EN]) begin
				sweeping_reg <= 1'b0;
			end else if (take_msb) begin
				msb_taken_reg <= 1'b1;
				capture_reg <= err_cnt_reg;
				err_cnt_reg <= 16'h0000;
				win_cnt_reg <= 18'h00000;
				if (point_reg != `LAST_POINT) begin
					point_reg <= point_reg + 12'h001;
				end
			end else if (take_lsb) begin
				msb_taken_reg <= 1'b0;
				pending_reg <= capture_reg;
				hold_reg <= pending_reg;
				pairs_reg <= pairs_reg + 13'h0001;
				if (pairs_reg == `LAST_PAIR) begin
					sweeping_reg <= 1'b0;
				end
			end else if (sweeping_reg && !win_end && sample_valid) begin
				win_cnt_reg <= win_cnt_reg + 18'h00001;
				if (is_error && err_cnt_reg != 16'hFFFF) begin
					err_cnt_reg <= err_cnt_reg + 16'h0001;
				end
			end
		end
	end

	// lock validation, power and range control
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			period_cnt_reg <= 13'h0000;
			check_pending_reg <= 1'b0;
			eye_check_req <= 1'b0;
			lock_restart <= 1'b0;
			horiz_reg <= 8'h00;
			vert_reg <= 8'h00;
			eye_power_on <= 1'b0;
			range_sel <= 2'b00;
		end else if (ce) begin
			eye_check_req <= 1'b0;
			lock_restart <= 1'b0;
			if (opening_valid) begin
				horiz_reg <= horizontal_opening_in;
				vert_reg <= vertical_opening_in;
				if (check_pending_reg) begin
					check_pending_reg <= 1'b0;
					lock_restart <= below & lock_check_reg[`BIT_LOCK_CHECK];
				end
			end
			if (lock_check_reg[`BIT_LOCK_CHECK] && cdr_locked) begin
				if (period_cnt_reg == CHECK_PERIOD[12:0] - 13'h0001) begin
					period_cnt_reg <= 13'h0000;
					eye_check_req <= 1'b1;
					check_pending_reg <= 1'b1;
				end else begin
					period_cnt_reg <= period_cnt_reg + 13'h0001;
				end
			end else begin
				period_cnt_reg <= 13'h0000;
				check_pending_reg <= 1'b0;
			end
			eye_power_on <= ~range_power_reg[`BIT_POWER_DOWN] | check_pending_reg
				| cdr_eye_use | sweeping_reg;
			range_sel <= range_ovr_reg[`BIT_RANGE_OVR] ? cdr_range
				: range_power_reg[`BIT_RANGE_HI:`BIT_RANGE_LO];
		end
	end
endmodule // eye_monitor_sweep_readout

// ===== test/smb_host.sv
// serial management controller model that drives the readout's bus pins
`timescale 1ns/100ps
module smb_host (
	// clock
	input wire clock,
	// bus pins, wire level worked out here from both enables
	input wire sda_oe,
	output logic scl,
	output wire sda
);
	logic m_oe = 1'b0;
	initial scl = 1'b1;
	// pulled-up line, reads high once both parties release it
	assign sda = !(sda_oe | m_oe);
	task automatic q(input int n);
		repeat (n) @(posedge clock);
	endtask
	// one 160 ns bit: data changes only while the clock is low
	task automatic bitx(input logic b, output logic r);
		q(10);
		m_oe <= !b;
		q(10);
		scl <= 1'b1;
		q(20);
		r = sda;
		scl <= 1'b0;
	endtask
	task automatic start();
		q(10);
		m_oe <= 1'b0;
		q(10);
		scl <= 1'b1;
		q(20);
		m_oe <= 1'b1;
		q(20);
		scl <= 1'b0;
	endtask
	// clock stays high between frames
	task automatic stop();
		q(10);
		m_oe <= 1'b1;
		q(10);
		scl <= 1'b1;
		q(20);
		m_oe <= 1'b0;
		q(20);
	endtask
	task automatic send(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) bitx(d[i], r);
		bitx(1'b1, r);
		ack = !r;
	endtask
	task automatic recv(input logic last, output logic [7:0] d);
		logic r;
		for (int i = 0; i < 8; i++) begin
			bitx(1'b1, r);
			d = {d[6:0], r};
		end
		bitx(last, r);
	endtask
endmodule // smb_host

// ===== test/eye_monitor_sweep_readout_sva.sv
// port assertions for the eye monitor sweep readout
`timescale 1ns/100ps
module eye_monitor_sweep_readout_sva #(
	parameter CHECK_PERIOD = 4096,
	parameter [6:0] SLAVE_ADDR = 7'h18
) (
	input wire clock, rst_n, ce, scl_in, sda_in, sda_out, sda_oe,
	input wire sample_valid, primary_bit, offset_bit, opening_valid,
	input wire [7:0] horizontal_opening_in, vertical_opening_in,
	input wire cdr_locked, cdr_eye_use,
	input wire [1:0] cdr_range,
	input wire eye_check_req, lock_restart, eye_power_on,
	input wire [1:0] range_sel,
	input wire eye_override,
	input wire [5:0] phase_offset, voltage_offset,
	input wire [7:0] channel_select
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);
	// cycles since the last lock-check request
	int gap;
	always @(posedge clock or negedge rst_n)
		if (!rst_n) gap <= 1 << 20;
		else if (eye_check_req) gap <= 0;
		else if (gap < (1 << 20)) gap <= gap + 1;
	chk_req_locked: assert property (!cdr_locked [*3] |-> !eye_check_req)
		else $error("check request while unlocked");
	chk_req_spacing: assert property (eye_check_req |-> gap >= CHECK_PERIOD - 1)
		else $error("check requests too close");
	chk_restart_cause: assert property (lock_restart |-> $past(opening_valid)
		|| $past(opening_valid, 2)) else $error("restart without a measurement");
	chk_restart_pulse: assert property (lock_restart |=> !lock_restart)
		else $error("restart longer than one cycle");
	chk_phase_step: assert property ($changed(phase_offset) |->
		phase_offset == $past(phase_offset) + 6'h01 || phase_offset == 6'h00)
		else $error("phase offset skipped a point");
	chk_volt_carry: assert property ($changed(voltage_offset) |-> phase_offset == 6'h00)
		else $error("voltage stepped before phase wrap");
	chk_power_sweep: assert property ($changed(phase_offset) |-> eye_power_on)
		else $error("offsets moved while unpowered");
	chk_sda_setup: assert property ($rose(sda_oe) |-> !scl_in && $past(scl_in, 2) == 1'b0)
		else $error("data driven while clock high");
	chk_open_drain: assert property (sda_oe |-> sda_out == 1'b0)
		else $error("data pin driven high");
	cover property (lock_restart);
	cover property ($changed(voltage_offset));
	cover property ($rose(sda_oe));
endmodule // eye_monitor_sweep_readout_sva
bind eye_monitor_sweep_readout eye_monitor_sweep_readout_sva #(.CHECK_PERIOD(CHECK_PERIOD),
	.SLAVE_ADDR(SLAVE_ADDR)) u_sva (.clock(clock), .rst_n(rst_n), .ce(ce), .scl_in(scl_in),
	.sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .sample_valid(sample_valid),
	.primary_bit(primary_bit), .offset_bit(offset_bit), .opening_valid(opening_valid),
	.horizontal_opening_in(horizontal_opening_in), .vertical_opening_in(vertical_opening_in),
	.cdr_locked(cdr_locked), .cdr_eye_use(cdr_eye_use), .cdr_range(cdr_range),
	.eye_check_req(eye_check_req), .lock_restart(lock_restart), .eye_power_on(eye_power_on),
	.range_sel(range_sel), .eye_override(eye_override), .phase_offset(phase_offset),
	.voltage_offset(voltage_offset), .channel_select(channel_select));

// ===== test/test_eye_monitor_sweep_readout.sv
// self-checking bench for the eye monitor sweep readout
`timescale 1ns/100ps
`include "eye_monitor_map.vh"
module test_eye_monitor_sweep_readout;
	logic clock = 1'b0, rst_n = 1'b0, ov = 1'b0, ob = 1'b0, pb = 1'b1, lk = 1'b0;
	logic [1:0] cr = 2'h2;
	logic [7:0] ho = 8'h80, vo = 8'h80;
	wire scl, sda, sda_oe, so, req, rst_pulse, pwr, ovr;
	wire [1:0] rng;
	wire [7:0] chs;
	wire [5:0] ph, vt;
	int errors = 0, compares = 0, n_req = 0, n_rst = 0;
	always #2 clock = !clock;
	eye_monitor_sweep_readout #(.CHECK_PERIOD(16)) dut (.clock(clock), .rst_n(rst_n),
		.ce(1'b1), .scl_in(scl), .sda_in(sda), .sda_out(so), .sda_oe(sda_oe),
		.sample_valid(1'b1), .primary_bit(pb), .offset_bit(ob), .opening_valid(ov),
		.horizontal_opening_in(ho), .vertical_opening_in(vo), .cdr_locked(lk),
		.cdr_eye_use(1'b0), .cdr_range(cr), .eye_check_req(req), .lock_restart(rst_pulse),
		.eye_power_on(pwr), .range_sel(rng), .eye_override(ovr), .phase_offset(ph),
		.voltage_offset(vt), .channel_select(chs));
	smb_host bus (.clock(clock), .sda_oe(sda_oe), .scl(scl), .sda(sda));
	// measurement answers each request; the two comparators always disagree
	always @(posedge clock) begin
		ov <= req;
		ob <= !ob;
		pb <= ob;
		if (req) n_req++;
		if (rst_pulse) n_rst++;
	end
	task automatic chk(input logic [15:0] got, exp);
		compares++;
		if (got !== exp) begin
			errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, d);
		logic k1, k2, k3;
		bus.start();
		bus.send({`SLAVE_ADDR, 1'b0}, k1);
		bus.send(a, k2);
		bus.send(d, k3);
		bus.stop();
		chk({k1, k2, k3}, 3'h7);
	endtask
	task automatic open_rd(input logic [7:0] a);
		logic k1, k2, k3;
		bus.start();
		bus.send({`SLAVE_ADDR, 1'b0}, k1);
		bus.send(a, k2);
		bus.start();
		bus.send({`SLAVE_ADDR, 1'b1}, k3);
		chk({k1, k2, k3}, 3'h7);
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		open_rd(a);
		bus.recv(1'b1, d);
		bus.stop();
	endtask
	task automatic t_reset();
		logic [7:0] d;
		rd(`OFF_RANGE_POWER, d);
		chk(d, 8'h20);
		rd(`OFF_OVERRIDE, d);
		chk({d, ovr}, 9'h000);
		rd(`OFF_ACCUM_TIME, d);
		chk(d, 8'h0F);
		rd(8'h30, d);
		chk(d, 8'h00);
		chk(so, 1'b0);
		$display("reset values done");
	endtask
	task automatic t_lock();
		int n0;
		logic [7:0] d;
		@(posedge clock);
		vo <= 8'h3F;
		ho <= 8'h40;
		repeat (40) @(posedge clock);
		n0 = n_rst;
		repeat (100) @(posedge clock);
		#1 chk(n_rst > n0, 1'b1);
		@(posedge clock);
		vo <= 8'h40;
		repeat (40) @(posedge clock);
		n0 = n_rst;
		repeat (100) @(posedge clock);
		#1 chk(n_rst == n0, 1'b1);
		chk(n_req >= 10, 1'b1);
		@(posedge clock);
		lk <= 1'b0;
		repeat (2) @(posedge clock);
		n0 = n_req;
		repeat (100) @(posedge clock);
		#1 chk(n_req == n0, 1'b1);
		@(posedge clock);
		lk <= 1'b1;
		rd(`OFF_HORIZ_OPEN, d);
		chk(d, 8'h40);
		wr(`OFF_LOCK_CHECK, 8'h00);
		n0 = n_req;
		repeat (100) @(posedge clock);
		#1 chk(n_req == n0, 1'b1);
		$display("lock check done");
	endtask
	task automatic t_range();
		wr(`OFF_RANGE_OVR, 8'h00);
		for (int r = 0; r < 4; r++) begin
			wr(`OFF_RANGE_POWER, {r[1:0], 6'h00});
			repeat (4) @(posedge clock);
			chk({pwr, rng}, {1'b1, r[1:0]});
		end
		wr(`OFF_RANGE_POWER, 8'h20);
		repeat (4) @(posedge clock);
		chk(pwr, 1'b0);
		wr(`OFF_RANGE_OVR, 8'h40);
		repeat (4) @(posedge clock);
		chk(rng, 2'h2);
		cr <= 2'h1;
		repeat (4) @(posedge clock);
		chk(rng, 2'h1);
		$display("range done");
	endtask
	task automatic t_single();
		logic [7:0] hi, lo;
		logic [5:0] p;
		wr(`OFF_CHAN_SEL, 8'h03);
		chk(chs, 8'h03);
		wr(`OFF_ACCUM_TIME, 8'h00);
		wr(`OFF_SWEEP_CTRL, 8'h81);
		rd(`OFF_SWEEP_CTRL, hi);
		chk(hi, 8'h81);
		for (int i = 0; i < 4; i++) begin
			p = ph;
			rd(`OFF_COUNT_HIGH, hi);
			chk(ph, 6'(p + 6'h01));
			rd(`OFF_COUNT_LOW, lo);
			chk({hi, lo}, i < 2 ? 16'h0000 : 16'h03FF);
		end
		$display("single byte reads done");
	endtask
	task automatic t_burst();
		logic [7:0] d;
		logic [11:0] pt;
		pt = {vt, ph};
		for (int k = 0; k < 2; k++) begin
			open_rd(`OFF_COUNT_HIGH);
			for (int i = 0; i < 62; i++) begin
				bus.recv(i == 61, d);
				if (k == 0 && i < 4) chk(d, i[0] ? 8'hFF : 8'h03);
			end
			bus.stop();
		end
		chk({vt, ph}, 12'(pt + 12'h03E));
		wr(`OFF_SWEEP_CTRL, 8'h00);
		rd(`OFF_SWEEP_CTRL, d);
		chk(d, 8'h00);
		wr(`OFF_RANGE_POWER, 8'h20);
		wr(`OFF_LOCK_CHECK, 8'h80);
		$display("burst reads done");
	endtask
	task automatic give_verdict();
		$display("compares %0d errors %0d", compares, errors);
		if (errors == 0 && compares > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	initial begin
		repeat (16) @(posedge clock);
		rst_n <= 1'b1;
		lk <= 1'b1;
		repeat (4) @(posedge clock);
		t_reset();
		t_lock();
		t_range();
		t_single();
		t_burst();
		give_verdict();
	end
endmodule // test_eye_monitor_sweep_readout
